// >>> dv/tb_vectored_priority_interrupt_ctrl.sv
/*
 tb: self-checking bench for the controller joined to its core end.
 assumes vic_pkg, vic_if and both design modules are compiled first.
*/
`timescale 1ns/1ns
module tb_vectored_priority_interrupt_ctrl;
	import vic_pkg::*;
	logic                   clk = 1'h0;
	logic                   rst_b = 1'h0;
	logic [SRC_N-1:0]       irq = '0;
	logic [SRC_N*VEC_W-1:0] src_vec;
	logic [8:0]             avs_address = 9'h000;
	logic                   avs_read = 1'h0;
	logic                   avs_write = 1'h0;
	logic [31:0]            avs_writedata = 32'h0;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   take;
	logic [VEC_W-1:0]       take_vec;
	logic [SET_W-1:0]       cur_set;
	logic                   exc_level;
	logic [31:0]            rd_q;
	int                     fail_count = 0;
	int                     check_count = 0;
	int                     takes = 0;
	int                     n;
	vic_if lnk ();
	vic_ctrl u_vic_ctrl (.clk(clk), .rst_b(rst_b), .irq(irq), .src_vec(src_vec), .lnk(lnk.ctrl));
	vic_core u_vic_core (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pc_in(32'h0000_1000), .take(take), .take_vec(take_vec), .cur_set(cur_set),
		.exc_level(exc_level), .lnk(lnk.core));
	vic_link_asserts u_vic_link_asserts (.clk(clk), .rst_b(rst_b),
		.req_valid(lnk.req_valid), .req_vec(lnk.req_vec), .req_lvl(lnk.req_lvl),
		.req_set(lnk.req_set), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
		.reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata));
	// clock and a count of taken interrupts
	always #2 clk = ~clk;
	always @(posedge clk) if (take === 1'h1) takes <= takes + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon cycle; held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0) @(posedge clk);
		rd_q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	// waits a bounded time for the next take
	task automatic wt();
		repeat (60) if (takes == n) @(posedge clk);
	endtask
	task automatic t_reset();
		rchk(9'h100, 32'h0);
		rchk(9'h120, 32'h0);
		rchk(9'h140, 32'h0);
		rchk(9'h010, BAD_READ);
	endtask
	task automatic t_regs();
		bus(1'h1, 9'h140, 32'hFFFF_FFFF);
		rchk(9'h140, 32'h1F1F_1F1F);
		bus(1'h1, 9'h140, 32'h0);
	endtask
	// vector 5 at level 2; single mode still hands out vector zero
	task automatic t_single();
		bus(1'h1, 9'h144, 32'h0000_0800);
		bus(1'h1, 9'h110, 32'h0000_0020);
		n = takes;
		irq[5] <= 1'h1;
		wt();
		chk(32'(takes), 32'(n + 1));
		chk(32'(take_vec), 32'h0);
		chk(32'(exc_level), 32'h1);
		chk(32'(cur_set), 32'(SET_SHADOW));
		rchk(9'h124, 32'h0000_0200);
		rchk(9'h100, 32'h0000_0020);
		rchk(9'h00C, 32'h0000_1000);
		irq[5] <= 1'h0;
		bus(1'h1, 9'h100, 32'h0);
		bus(1'h1, 9'h000, 32'h2);
		chk(32'(exc_level), 32'h0);
		chk(32'(cur_set), 32'(SET_MAIN));
		rchk(9'h004, 32'h0);
	endtask
	// flag latches while masked but nothing is taken
	task automatic t_mask();
		bus(1'h1, 9'h110, 32'h0);
		n = takes;
		irq[5] <= 1'h1;
		repeat (20) @(posedge clk);
		chk(32'(takes), 32'(n));
		rchk(9'h100, 32'h0000_0020);
		irq[5] <= 1'h0;
		bus(1'h1, 9'h100, 32'h0);
	endtask
	// second reset, so the mode is chosen only straight after initialisation
	task automatic t_rearm();
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rchk(9'h120, 32'h0);
	endtask
	// vector 4 is level 3 sub 0, 8 and 9 tie at level 3 sub 2, 12 is disabled
	task automatic t_multi();
		bus(1'h1, 9'h120, 32'h0000_1300);
		rchk(9'h120, 32'h0000_1300);
		bus(1'h1, 9'h144, 32'h0000_000C);
		bus(1'h1, 9'h148, 32'h0000_0E0E);
		bus(1'h1, 9'h004, 32'h3);
		bus(1'h1, 9'h110, 32'h0000_1310);
		n = takes;
		irq[15:0] <= 16'h1310;
		repeat (20) @(posedge clk);
		chk(32'(takes), 32'(n));
		rchk(9'h124, 32'h0000_0308);
		bus(1'h1, 9'h004, 32'h2);
		wt();
		chk(32'(takes), 32'(n + 1));
		chk(32'(take_vec), 32'h8);
		chk(32'(cur_set), 32'(SET_SHADOW));
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence; source s maps to vector s mod 64
	initial begin
		for (int s = 0; s < SRC_N; s++) src_vec[s*VEC_W +: VEC_W] = VEC_W'(s % VEC_N);
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		t_reset();
		t_regs();
		t_single();
		t_mask();
		t_rearm();
		t_multi();
		results();
	end
	// watchdog, far beyond the fewer than two hundred cycles the run needs
	initial begin
		#100000;
		fail_count++;
		results();
	end
endmodule // tb_vectored_priority_interrupt_ctrl

// >>> dv/vic_link_asserts.sv
/*
 vic_link_asserts: checks on the link between controller and core end.
 assumes one clk and async active-low rst_b; inputs are the vic_if signals.
*/
`timescale 1ns/1ns
module vic_link_asserts
	import vic_pkg::*;
(
	// clock and reset
	input wire logic             clk,
	input wire logic             rst_b,
	// presentation
	input wire logic             req_valid,
	input wire logic [VEC_W-1:0] req_vec,
	input wire logic [LVL_W-1:0] req_lvl,
	input wire logic [SET_W-1:0] req_set,
	// register link
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic [31:0]      reg_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// decode of the word touched on the link
	wire              ctrl_wr = reg_wr && reg_addr[7:2] == IDX_CTRL;
	wire              ctrl_rd = reg_rd && reg_addr[7:2] == IDX_CTRL;
	wire              stat_rd = reg_rd && reg_addr[7:2] == IDX_STAT;
	wire              prio_rd = reg_rd && reg_addr[7:6] == 2'h1;
	wire              prio_wr = reg_wr && reg_addr[7:6] == 2'h1;
	logic             mode_q;
	logic [LVL_W-1:0] ssl_q;
	logic [7:0]       pw_a_q;
	logic [31:0]      pw_d_q;
	// shadow copies so the checks need no look inside the controller
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= 1'h0;
			ssl_q <= 3'h0;
			pw_a_q <= 8'h00;
			pw_d_q <= 32'h0;
		end else begin
			if (ctrl_wr) begin
				mode_q <= reg_wdata[CTRL_MODE_BIT];
				ssl_q <= reg_wdata[CTRL_SSL_LSB +: LVL_W];
			end
			if (prio_wr) begin
				pw_a_q <= reg_addr;
				pw_d_q <= reg_wdata & 32'h1F1F_1F1F;
			end
		end
	end
	a_level_nonzero: assert property (req_valid |-> req_lvl != 3'h0)
		else $error("presented level is zero");
	a_single_vec: assert property (req_valid && !mode_q && !$past(mode_q) |-> req_vec == 6'h00)
		else $error("nonzero vector in single mode");
	a_prio_top: assert property (prio_rd |=> (reg_rdata & 32'hE0E0_E0E0) == 32'h0)
		else $error("priority bank top bits not zero");
	a_prio_echo: assert property (prio_rd && reg_addr == pw_a_q |=> reg_rdata == $past(pw_d_q))
		else $error("priority bank readback wrong");
	a_stat_zero: assert property (stat_rd |=> reg_rdata[31:11] == 21'h0 && reg_rdata[7:6] == 2'h0)
		else $error("status reserved bits set");
	a_stat_mirror: assert property (stat_rd && req_valid |=>
		reg_rdata[10:0] == {$past(req_lvl), 2'h0, $past(req_vec)})
		else $error("status differs from presentation");
	a_mode_read: assert property (ctrl_rd |=> reg_rdata[CTRL_MODE_BIT] == $past(mode_q))
		else $error("mode bit readback wrong");
	a_shadow_pick: assert property (mode_q && $past(mode_q) && $stable(ssl_q) && req_valid |->
		req_set == (req_lvl == ssl_q ? SET_SHADOW : SET_MAIN))
		else $error("shadow set choice wrong");
	a_shadow_single: assert property (!mode_q && !$past(mode_q) && req_valid |->
		req_set == SET_SHADOW)
		else $error("single mode request not on shadow set");
endmodule // vic_link_asserts

// >>> pkg/vic_if.sv
/*
 vic_if: link between the interrupt controller and the core end.
 assumes both ends run on the same clk; the controller owns the register file.
*/
`timescale 1ns/1ns
interface vic_if;
	import vic_pkg::*;
	logic              req_valid;
	logic [VEC_W-1:0]  req_vec;
	logic [LVL_W-1:0]  req_lvl;
	logic [SET_W-1:0]  req_set;
	logic              reg_wr;
	logic              reg_rd;
	logic [7:0]        reg_addr;
	logic [31:0]       reg_wdata;
	logic [31:0]       reg_rdata;
	modport ctrl (output req_valid, req_vec, req_lvl, req_set, reg_rdata,
		input reg_wr, reg_rd, reg_addr, reg_wdata);
	modport core (input req_valid, req_vec, req_lvl, req_set, reg_rdata,
		output reg_wr, reg_rd, reg_addr, reg_wdata);
endinterface // vic_if

// >>> pkg/vic_pkg.sv
/*
 vic_pkg: shared constants for the vectored priority interrupt controller and its core end.
 assumes a single system clock, zero reset values and a 32-bit register bus.
*/
package vic_pkg;
	localparam int unsigned SRC_N      = 96;   // request inputs
	localparam int unsigned VEC_N      = 64;   // vector numbers
	localparam int unsigned VEC_W      = 6;
	localparam int unsigned LVL_W      = 3;
	localparam int unsigned SUB_W      = 2;
	localparam int unsigned SET_W      = 2;    // shadow set number width
	localparam int unsigned BANK_N     = 3;    // 32-bit flag and enable banks
	localparam int unsigned PRIO_N     = 16;   // priority banks, four slots each
	// register word indices inside the controller window
	localparam logic [5:0] IDX_FLAG    = 6'h00; // 0..2
	localparam logic [5:0] IDX_EN      = 6'h04; // 4..6
	localparam logic [5:0] IDX_CTRL    = 6'h08;
	localparam logic [5:0] IDX_STAT    = 6'h09;
	localparam logic [5:0] IDX_PRIO    = 6'h10; // 16..31
	// interrupt control register fields
	localparam int unsigned CTRL_MODE_BIT = 12;
	localparam int unsigned CTRL_SSL_LSB  = 8;  // shadow-set level, bits 10:8
	// status register fields
	localparam int unsigned STAT_VEC_LSB = 0;
	localparam int unsigned STAT_LVL_LSB = 8;
	// slot layout inside a byte of a priority bank
	localparam int unsigned SLOT_SUB_LSB = 0;
	localparam int unsigned SLOT_LVL_LSB = 2;
	localparam logic [7:0]  SLOT_MASK    = 8'h1F; // bits 7:5 always read zero
	localparam logic [31:0] RESET_VAL    = 32'h0000_0000;
	localparam logic [SET_W-1:0] SET_MAIN   = 2'h0;
	localparam logic [SET_W-1:0] SET_SHADOW = 2'h1;
	// core-end command register map (byte addresses)
	localparam logic [7:0] CORE_A_CMD  = 8'h00; // bit1 return; bit0 has no effect
	localparam logic [7:0] CORE_A_LVL  = 8'h04; // current level 2:0
	localparam logic [7:0] CORE_A_STAT = 8'h08;
	localparam logic [7:0] CORE_A_RET  = 8'h0C; // saved program counter
	localparam logic [31:0] BAD_READ   = 32'hDEAD_0BAD;
endpackage

// >>> rtl/vic_core.sv
/*
 vic_core: core end; takes presented interrupts above its level and bridges
 software's Avalon-MM accesses onto the controller register link.
 assumes the controller answers a link read one clock later.
*/
`timescale 1ns/1ns
module vic_core
	import vic_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// avalon-mm slave: 0x000-0x0FF core registers, 0x100-0x1FF controller
	input  wire logic [8:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// program counter seen by the core
	input  wire logic [31:0] pc_in,
	// taken interrupt
	output logic             take,
	output logic [VEC_W-1:0] take_vec,
	output logic [SET_W-1:0] cur_set,
	output logic             exc_level,
	// link
	vic_if.core              lnk
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WAIT  = 4'b0010,
		ST_FETCH = 4'b0100,
		ST_DONE  = 4'b1000
	} bus_e;
	bus_e              st_q;
	logic [LVL_W-1:0]  lvl_q;
	logic [LVL_W-1:0]  prev_lvl_q;
	logic [SET_W-1:0]  set_q;
	logic [SET_W-1:0]  prev_set_q;
	logic              exl_q;
	logic [31:0]       ret_q;
	logic              take_q;
	logic [VEC_W-1:0]  tvec_q;
	logic [31:0]       rd_q;
	logic              wr_q;
	logic              rdl_q;
	logic [7:0]        adr_q;
	logic [31:0]       wd_q;
	logic              wait_q;

	wire to_ctrl = avs_address[8];
	wire req     = avs_read | avs_write;
	wire do_cmd  = st_q == ST_DONE && avs_write && !to_ctrl && avs_address[7:0] == CORE_A_CMD;
	// only above the current level, and never while the exception level is set
	wire can_take = lnk.req_valid && lnk.req_lvl > lvl_q && !exl_q;
	wire do_ret   = do_cmd && avs_writedata[1] && exl_q;

	logic [31:0] local_rd;
	always_comb begin
		local_rd = '0;
		if (avs_address[7:0] == CORE_A_LVL) begin
			local_rd[LVL_W-1:0] = lvl_q;
		end else if (avs_address[7:0] == CORE_A_STAT) begin
			local_rd = {24'h0, exl_q, 1'b0, set_q, 1'b0, lvl_q};
		end else if (avs_address[7:0] == CORE_A_RET) begin
			local_rd = ret_q;
		end else if (avs_address[7:0] != CORE_A_CMD) begin
			local_rd = BAD_READ;
		end
	end

	// bus sequencer: local accesses and controller writes answer on the second edge;
	// controller reads need two more, for the link read and for the copy into rd_q
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q   <= ST_IDLE;
			wait_q <= 1'b1;
			rd_q   <= '0;
			wr_q   <= 1'b0;
			rdl_q  <= 1'b0;
			adr_q  <= '0;
			wd_q   <= '0;
		end else begin
			wr_q   <= 1'b0;
			rdl_q  <= 1'b0;
			wait_q <= 1'b1;
			case (st_q)
				ST_IDLE: begin
					if (req && to_ctrl) begin
						wr_q   <= avs_write;
						rdl_q  <= avs_read;
						adr_q  <= avs_address[7:0];
						wd_q   <= avs_writedata;
						st_q   <= avs_read ? ST_WAIT : ST_DONE;
						wait_q <= avs_read;
					end else if (req) begin
						if (avs_read) begin
							rd_q <= local_rd; // a write leaves the last read data standing
						end
						st_q   <= ST_DONE;
						wait_q <= 1'b0;
					end
				end
				ST_WAIT: begin
					st_q <= ST_FETCH; // the controller latches its word on this edge
				end
				ST_FETCH: begin
					rd_q   <= lnk.reg_rdata;
					st_q   <= ST_DONE;
					wait_q <= 1'b0;
				end
				ST_DONE: begin
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// taking, level and return bookkeeping
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_q      <= '0;
			prev_lvl_q <= '0;
			set_q      <= SET_MAIN;
			prev_set_q <= SET_MAIN;
			exl_q      <= 1'b0;
			ret_q      <= '0;
			take_q     <= 1'b0;
			tvec_q     <= '0;
		end else begin
			take_q <= can_take;
			if (can_take) begin
				ret_q      <= pc_in;
				exl_q      <= 1'b1;
				tvec_q     <= lnk.req_vec;
				prev_lvl_q <= lvl_q;
				prev_set_q <= set_q;
				lvl_q      <= lnk.req_lvl;
				set_q      <= lnk.req_set;
			end else if (do_ret) begin
				exl_q <= 1'b0;
				lvl_q <= prev_lvl_q;
				set_q <= prev_set_q;
			end else if (st_q == ST_DONE && avs_write && !to_ctrl
				&& avs_address[7:0] == CORE_A_LVL) begin
				lvl_q <= avs_writedata[LVL_W-1:0];
			end
		end
	end

	assign avs_readdata    = rd_q;
	assign avs_waitrequest = wait_q;
	assign take            = take_q;
	assign take_vec        = tvec_q;
	assign cur_set         = set_q;
	assign exc_level       = exl_q;
	assign lnk.reg_wr      = wr_q;
	assign lnk.reg_rd      = rdl_q;
	assign lnk.reg_addr    = adr_q;
	assign lnk.reg_wdata   = wd_q;
endmodule // vic_core

// >>> rtl/vic_ctrl.sv
/*
 vic_ctrl: request latching, masking, priority selection and vector presentation.
 assumes request lines are already on clk; registers are written through the link.
*/
`timescale 1ns/1ns
// Behaviour
// - flag reads one after request, else zero
// - enable bit one allows, zero blocks source
// - priority codes one to seven, zero disables
// - subpriority codes zero to three directly
// - four slots per priority bank, fixed fields
// - top three bits of each byte read zero
// - ninety-six request inputs accepted
// - requests sampled on rising clock edge
// - disabled flags take no part in selection
// - requests map to six-bit vector numbers
// - each vector carries level and shadow set
// - shadow set per chosen level or all
// - highest priority pending request is presented
// - core takes only above its current level
// - core saves counter, sets exception level
// - return clears level, restores counter, set; the core restores set and lvl_q but drives no counter
// - status shows pending vector and level; its vector field reads zero in single-vector mode
// - single-vector default, multi-vector optional
// - software keeps mode fixed after setup
// - controller drives core in external mode
// - control bit twelve selects multi-vector mode
// - single-vector mode always presents vector zero
module vic_ctrl
	import vic_pkg::*;
#(
	parameter int unsigned SRCS = SRC_N
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_b,
	// request sources
	input  wire logic [SRCS-1:0] irq,
	// source to vector map, six bits per source
	input  wire logic [SRCS*VEC_W-1:0] src_vec,
	// link to the core
	vic_if.ctrl                  lnk
);
	logic [SRCS-1:0]       flag_q;
	logic [SRCS-1:0]       en_q;
	logic [7:0]            slot_q [VEC_N];
	logic                  mode_q;
	logic [LVL_W-1:0]      ssl_q;
	logic                  valid_q;
	logic [VEC_W-1:0]      vec_q;
	logic [LVL_W-1:0]      lvl_q;
	logic [SET_W-1:0]      set_q;
	logic [31:0]           rdata_q;

	wire [5:0] widx = lnk.reg_addr[7:2];

	// register decode for the read mux; hit_ctrl and hit_prio also gate the control and priority writes
	wire hit_flag = widx < IDX_FLAG + 6'(BANK_N);
	wire hit_en   = widx >= IDX_EN && widx < IDX_EN + 6'(BANK_N);
	wire hit_ctrl = widx == IDX_CTRL;
	wire hit_stat = widx == IDX_STAT;
	wire hit_prio = widx >= IDX_PRIO; // upper half of the window aliases the priority banks

	// word index of the flag or enable bank that holds source s
	function automatic logic [5:0] bank_idx(input logic [5:0] base, input int s);
		return base + 6'(s / 32);
	endfunction

	// slot number of byte j in a priority bank word
	function automatic logic [VEC_W-1:0] slot_idx(input logic [5:0] w, input int j);
		return {w[3:0], 2'(j)};
	endfunction

	// level above subpriority, so one unsigned compare ranks both
	function automatic logic [LVL_W+SUB_W-1:0] slot_key(input logic [7:0] s);
		return s[SLOT_SUB_LSB +: LVL_W+SUB_W];
	endfunction

	// per-vector pending: any enabled flag mapped to it
	// the map is read live, so changing src_vec moves pending flags at once
	logic [VEC_N-1:0] vec_pend;
	always_comb begin
		vec_pend = '0;
		for (int s = 0; s < SRCS; s++) begin
			if (flag_q[s] && en_q[s]) begin
				vec_pend[src_vec[s*VEC_W +: VEC_W]] = 1'b1;
			end
		end
	end

	// score = level then subpriority; lowest vector wins ties by strict compare
	logic [VEC_W-1:0] win_vec;
	logic [LVL_W-1:0] win_lvl;
	logic [4:0]       win_key;
	logic             win_any;
	always_comb begin
		win_vec = '0;
		win_lvl = '0;
		win_key = '0;
		win_any = 1'b0;
		for (int v = 0; v < VEC_N; v++) begin
			// level zero disables the vector entirely
			if (vec_pend[v] && slot_q[v][SLOT_LVL_LSB +: LVL_W] != 3'h0
				&& slot_key(slot_q[v]) > win_key) begin
				win_key = slot_key(slot_q[v]);
				win_vec = VEC_W'(v);
				win_lvl = slot_q[v][SLOT_LVL_LSB +: LVL_W];
				win_any = 1'b1;
			end
		end
	end

	// shadow set: every request in single mode, else only the chosen level
	wire [SET_W-1:0] win_set = (!mode_q || win_lvl == ssl_q) ? SET_SHADOW : SET_MAIN;
	wire [VEC_W-1:0] shown_vec = mode_q ? win_vec : '0;

	function automatic logic [31:0] bank_word(input logic [SRCS-1:0] b, input int k);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < 32; i++) begin
			if (k*32+i < SRCS) w[i] = b[k*32+i];
		end
		return w;
	endfunction

	// register reads, decoded by word index
	logic [31:0] rd_word;
	always_comb begin
		rd_word = '0;
		if (hit_flag) begin
			rd_word = bank_word(flag_q, int'(widx - IDX_FLAG));
		end else if (hit_en) begin
			rd_word = bank_word(en_q, int'(widx - IDX_EN));
		end else if (hit_ctrl) begin
			rd_word[CTRL_MODE_BIT] = mode_q;
			rd_word[CTRL_SSL_LSB +: LVL_W] = ssl_q;
		end else if (hit_stat) begin
			rd_word[STAT_VEC_LSB +: VEC_W] = vec_q;
			rd_word[STAT_LVL_LSB +: LVL_W] = lvl_q;
		end else if (hit_prio) begin
			for (int j = 0; j < 4; j++) begin
				rd_word[j*8 +: 8] = slot_q[slot_idx(widx, j)] & SLOT_MASK;
			end
		end
	end

	// flags: a request in the same cycle as a software clear wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= '0;
		end else begin
			for (int s = 0; s < SRCS; s++) begin
				if (lnk.reg_wr && widx == bank_idx(IDX_FLAG, s)) begin
					flag_q[s] <= lnk.reg_wdata[s%32] | irq[s];
				end else begin
					flag_q[s] <= flag_q[s] | irq[s];
				end
			end
		end
	end

	// enables, control and priority slots
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q   <= '0;
			mode_q <= 1'b0;
			ssl_q  <= '0;
			for (int v = 0; v < VEC_N; v++) slot_q[v] <= '0;
		end else if (lnk.reg_wr) begin
			for (int s = 0; s < SRCS; s++) begin
				if (widx == bank_idx(IDX_EN, s)) en_q[s] <= lnk.reg_wdata[s%32];
			end
			if (hit_ctrl) begin
				mode_q <= lnk.reg_wdata[CTRL_MODE_BIT];
				ssl_q  <= lnk.reg_wdata[CTRL_SSL_LSB +: LVL_W];
			end
			if (hit_prio) begin
				for (int j = 0; j < 4; j++) begin
					slot_q[slot_idx(widx, j)] <= lnk.reg_wdata[j*8 +: 8] & SLOT_MASK;
				end
			end
		end
	end

	// presented request and read data, registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			valid_q <= 1'b0;
			vec_q   <= '0;
			lvl_q   <= '0;
			set_q   <= '0;
			rdata_q <= RESET_VAL;
		end else begin
			valid_q <= win_any;
			vec_q   <= shown_vec;
			lvl_q   <= win_lvl;
			set_q   <= win_set;
			rdata_q <= lnk.reg_rd ? rd_word : rdata_q;
		end
	end

	assign lnk.req_valid = valid_q;
	assign lnk.req_vec   = vec_q;
	assign lnk.req_lvl   = lvl_q;
	assign lnk.req_set   = set_q;
	assign lnk.reg_rdata = rdata_q;
endmodule // vic_ctrl
